/* hdl/bctl_regs.svh */
/*
 Register offsets, field positions, reset values and command layout of the
 branch cache tuning and lock block. Assumes it is included by bare name.
*/
`ifndef BCTL_REGS_SVH
`define BCTL_REGS_SVH

// -----------------------------------------------------------------
// Device special function registers
// -----------------------------------------------------------------
`define BCTL_TUNING_ADDR 8'hc9
`define BCTL_LOCK_ADDR 8'hd2
`define BCTL_ACC_ADDR 8'hd3
`define BCTL_TUNING_RST 8'h04
`define BCTL_LOCK_RST 8'h1f
`define BCTL_ACC_RST 8'h00
`define BCTL_ALG_BIT 3
`define BCTL_FIX_BIT 2
`define BCTL_PUSH_BIT 7
`define BCTL_POP_BIT 6
`define BCTL_RSVD_BIT 5
`define BCTL_OVF_BIT 7
`define BCTL_PTR_NOPOP 5'h1e
`define BCTL_PTR_LAST 5'h01

// -----------------------------------------------------------------
// Controller registers on APB
// -----------------------------------------------------------------
`define BCTL_CMD_OFS 8'h00
`define BCTL_STATUS_OFS 8'h04
`define BCTL_CMD_WE_BIT 16
`define BCTL_CMD_SEQ_BIT 17
`define BCTL_ST_BUSY_BIT 8
`define BCTL_ST_REFUSED_BIT 9
`define BCTL_ST_OVF_BIT 24

`endif

/* hdl/bctl_pkg.sv */
/*
 Types shared by the branch cache tuning and lock ends.
 Assumes the register header is compiled alongside.
*/
package bctl_pkg;

   // Controller sequencer, Gray coded along the read sequence.
   typedef enum logic [1:0] {
      BCTL_IDLE = 2'b00,
      BCTL_WAIT1 = 2'b01,
      BCTL_ISSUE2 = 2'b11,
      BCTL_WAIT2 = 2'b10
   } bctl_state_e;

endpackage

/* hdl/bctl_if.sv */
/*
 Special function register access path between the controller end and the
 cache tuning device. Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface bctl_if;
   logic req;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;

   modport dev (
      input req,
      input we,
      input addr,
      input wdata,
      output ack,
      output rdata
   );

   modport ctl (
      output req,
      output we,
      output addr,
      output wdata,
      input ack,
      input rdata
   );
endinterface

/* hdl/bctl_lfsr.sv */
/*
 Free running maximal length shift register for pseudo-random slot choice.
 Assumes a nonzero seed; taps suit the default width of five.
*/
`timescale 1ns/1ps

module bctl_lfsr #(
   parameter int W = 5,
   parameter logic [W-1:0] SEED = 5'h01
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Value
   output logic [W-1:0] rnd_o
);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rnd_o <= SEED;
      end else begin
         rnd_o <= {rnd_o[W-2:0], rnd_o[W-1] ^ rnd_o[2]};
      end
   end

endmodule // bctl_lfsr

/* hdl/bctl_device.sv */
/*
 Cache tuning, slot lock stack and miss penalty accumulator of a branch
 target cache. Assumes the fetch path raises stall_i in each cycle the core
 waits on a miss, then pulses fill_i in the cycle after the last such cycle.

// Notes on behaviour
// - Select bounce or pseudo-random replacement by bit.
// - Bounce walks up, then down, repeating.
// - Fixed-slot bit sends table-read fills to slot 0.
// - Cache only when stall exceeds miss threshold.
// - Threshold zero caches every stalling miss.
// - Push locks table-read segment, then decrements pointer.
// - Pop increments pointer; pop bit reads zero.
// - No pop at pointer 11110b, nor extra pops.
// - Pointer read-only; slots above it never replaced.
// - Pointer zero leaves whole cache unlocked.
// - At most thirty slots locked at once.
// - Reserved lock bit reads zero, written zero.
// - Accumulator counts every miss stall cycle.
// - Upper bits in accumulator register, lower in tuning.
// - Upper read latches lower bits for later.
// - Read upper field before lower field.
// - Upper write loads field, clears low five.
// - Bit zero hidden; total is twice fields.
// - Overflow flag sticky until accumulator written.
*/
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "bctl_regs.svh"

module bctl_device (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Register access
   bctl_if.dev sfr,
   // Fetch path
   input wire logic stall_i,
   input wire logic fill_i,
   input wire logic fill_table_read_i,
   // Cache array write port
   output logic cache_wr_o,
   output logic [4:0] cache_wr_slot_o
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [11:0] acc;
   logic acc_ovf;
   logic [3:0] lo_snap;
   logic alg_random;
   logic fixed_slot;
   logic [1:0] miss_threshold;
   logic lock_push_enable;
   logic [4:0] lock_slot_pointer;
   logic [2:0] stall_run;
   logic [4:0] bounce_idx;
   logic bounce_down;
   logic [4:0] rnd;

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   logic wr_tuning;
   logic wr_lock;
   logic wr_acc;
   logic rd_acc;
   logic lock_pop;
   logic [4:0] limit;
   logic [4:0] bounce_victim;
   logic [4:0] victim;
   logic do_push;
   logic do_fill;
   logic fix_hit;
   logic [4:0] slot;

   assign wr_tuning = sfr.req && sfr.we && (sfr.addr == `BCTL_TUNING_ADDR);
   assign wr_lock = sfr.req && sfr.we && (sfr.addr == `BCTL_LOCK_ADDR);
   assign wr_acc = sfr.req && sfr.we && (sfr.addr == `BCTL_ACC_ADDR);
   assign rd_acc = sfr.req && !sfr.we && (sfr.addr == `BCTL_ACC_ADDR);
   assign lock_pop = wr_lock && sfr.wdata[`BCTL_POP_BIT];

   // -----------------------------------------------------------------
   // Replacement choice
   // -----------------------------------------------------------------
   bctl_lfsr #(
      .W(5),
      .SEED(5'h01)
   ) u_lfsr (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .rnd_o(rnd)
   );

   // Unlocked slots run from zero up to the pointer; pointer zero unlocks every slot.
   assign limit = (lock_slot_pointer == 5'h00) ? 5'h1f : lock_slot_pointer;
   assign bounce_victim = (bounce_idx > limit) ? limit : bounce_idx;
   // A random value that lands on a locked slot falls back to the bounce
   // choice, which costs some randomness but never needs a divider.
   assign victim = (alg_random && (rnd <= limit)) ? rnd : bounce_victim;

   assign do_push = fill_i && fill_table_read_i && lock_push_enable;
   assign do_fill = fill_i && !do_push && (stall_run > {1'b0, miss_threshold});
   assign fix_hit = fill_table_read_i && fixed_slot;

   always_comb begin
      if (do_push) begin
         slot = lock_slot_pointer;
      end else if (fix_hit) begin
         slot = 5'h00;
      end else begin
         slot = victim;
      end
   end

   // -----------------------------------------------------------------
   // Tuning register
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         alg_random <= 1'(`BCTL_TUNING_RST >> `BCTL_ALG_BIT);
         fixed_slot <= 1'b1;
         miss_threshold <= 2'h0;
      end else if (wr_tuning) begin
         alg_random <= sfr.wdata[`BCTL_ALG_BIT];
         fixed_slot <= sfr.wdata[`BCTL_FIX_BIT];
         miss_threshold <= sfr.wdata[1:0];
      end
   end

   // -----------------------------------------------------------------
   // Lock stack
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lock_push_enable <= 1'b0;
      end else if (wr_lock) begin
         lock_push_enable <= sfr.wdata[`BCTL_PUSH_BIT];
      end
   end

   // Software cannot write the pointer; only push and pop move it.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lock_slot_pointer <= 5'h1f;
      end else if (do_push && !lock_pop) begin
         lock_slot_pointer <= lock_slot_pointer - 5'h01;
      end else if (lock_pop && !do_push) begin
         lock_slot_pointer <= lock_slot_pointer + 5'h01;
      end
   end

   // -----------------------------------------------------------------
   // Bounce walker
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bounce_idx <= 5'h00;
         bounce_down <= 1'b0;
      end else if (do_fill && !fix_hit && !alg_random) begin
         if (!bounce_down) begin
            if (bounce_victim >= limit) begin
               bounce_down <= 1'b1;
               bounce_idx <= bounce_victim - 5'h01;
            end else begin
               bounce_idx <= bounce_victim + 5'h01;
            end
         end else begin
            if (bounce_victim == 5'h00) begin
               bounce_down <= 1'b0;
               bounce_idx <= 5'h01;
            end else begin
               bounce_idx <= bounce_victim - 5'h01;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Miss stall length
   // -----------------------------------------------------------------
   // Saturates at seven, which is already above any threshold.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stall_run <= 3'h0;
      end else if (fill_i) begin
         stall_run <= 3'h0;
      end else if (stall_i && (stall_run != 3'h7)) begin
         stall_run <= stall_run + 3'h1;
      end
   end

   // -----------------------------------------------------------------
   // Miss penalty accumulator
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc <= 12'h000;
      end else if (wr_acc) begin
         acc <= {sfr.wdata[6:0], 5'h00};
      end else if (stall_i) begin
         acc <= acc + 12'h001;
      end
   end

   // An overflow in the same cycle as a write still sets the flag.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc_ovf <= 1'b0;
      end else if (stall_i && (acc == 12'hfff)) begin
         acc_ovf <= 1'b1;
      end else if (wr_acc) begin
         acc_ovf <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lo_snap <= 4'h0;
      end else if (rd_acc) begin
         lo_snap <= acc[4:1];
      end
   end

   // -----------------------------------------------------------------
   // Read answer
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sfr.ack <= 1'b0;
         sfr.rdata <= 8'h00;
      end else begin
         sfr.ack <= sfr.req;
         if (!sfr.req || sfr.we) begin
            sfr.rdata <= 8'h00;
         end else if (sfr.addr == `BCTL_TUNING_ADDR) begin
            sfr.rdata <= {lo_snap, alg_random, fixed_slot, miss_threshold};
         end else if (sfr.addr == `BCTL_LOCK_ADDR) begin
            sfr.rdata <= {lock_push_enable, 1'b0, 1'b0, lock_slot_pointer};
         end else if (sfr.addr == `BCTL_ACC_ADDR) begin
            sfr.rdata <= {acc_ovf, acc[11:5]};
         end else begin
            sfr.rdata <= 8'h00;
         end
      end
   end

   // -----------------------------------------------------------------
   // Cache write port
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cache_wr_o <= 1'b0;
         cache_wr_slot_o <= 5'h00;
      end else begin
         cache_wr_o <= do_push || do_fill;
         cache_wr_slot_o <= slot;
      end
   end

endmodule // bctl_device

/* hdl/bctl_host.sv */
/*
 Controller end: takes software orders over APB and turns them into
 register accesses of the cache tuning device. Assumes a single clock
 shared with the device and an APB master on the same clock.
*/
`timescale 1ns/1ps
`include "bctl_regs.svh"

module bctl_host (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Device access
   bctl_if.ctl sfr
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   bctl_pkg::bctl_state_e state;
   logic seq;
   logic refused;
   logic [7:0] last_rdata;
   logic [6:0] hi_field;
   logic [3:0] lo_field;
   logic ovf;
   logic [4:0] shadow_ptr;
   logic cmd_wr;
   logic busy;
   logic to_lock;
   logic bad;

   assign pready_o = 1'b1;
   assign busy = (state != bctl_pkg::BCTL_IDLE);
   assign cmd_wr = psel_i && penable_i && pwrite_i && (paddr_i == `BCTL_CMD_OFS);
   assign to_lock = pwdata_i[`BCTL_CMD_WE_BIT] && (pwdata_i[7:0] == `BCTL_LOCK_ADDR);
   // The pointer is known only from the last read of the lock register.
   assign bad = !pwdata_i[`BCTL_CMD_SEQ_BIT] && to_lock &&
      ((pwdata_i[8 + `BCTL_POP_BIT] && (shadow_ptr == `BCTL_PTR_NOPOP)) ||
      (pwdata_i[8 + `BCTL_PUSH_BIT] && (shadow_ptr == `BCTL_PTR_LAST)));

   // -----------------------------------------------------------------
   // APB read data
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else if (psel_i && !penable_i) begin
         if (paddr_i == `BCTL_CMD_OFS) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
         end else if (paddr_i == `BCTL_STATUS_OFS) begin
            prdata_o <= {7'h00, ovf, {hi_field, lo_field, 1'b0}, 2'h0, refused, busy, last_rdata};
            pslverr_o <= 1'b0;
         end else begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= bctl_pkg::BCTL_IDLE;
         seq <= 1'b0;
         sfr.req <= 1'b0;
         sfr.we <= 1'b0;
         sfr.addr <= 8'h00;
         sfr.wdata <= 8'h00;
      end else begin
         sfr.req <= 1'b0;
         case (state)
            bctl_pkg::BCTL_IDLE: begin
               if (cmd_wr && !bad) begin
                  seq <= pwdata_i[`BCTL_CMD_SEQ_BIT];
                  sfr.req <= 1'b1;
                  if (pwdata_i[`BCTL_CMD_SEQ_BIT]) begin
                     sfr.we <= 1'b0;
                     sfr.addr <= `BCTL_ACC_ADDR;
                     sfr.wdata <= 8'h00;
                  end else begin
                     sfr.we <= pwdata_i[`BCTL_CMD_WE_BIT];
                     sfr.addr <= pwdata_i[7:0];
                     sfr.wdata <= to_lock ? (pwdata_i[15:8] & 8'hdf) : pwdata_i[15:8];
                  end
                  state <= bctl_pkg::BCTL_WAIT1;
               end
            end
            bctl_pkg::BCTL_WAIT1: begin
               if (sfr.ack) begin
                  state <= seq ? bctl_pkg::BCTL_ISSUE2 : bctl_pkg::BCTL_IDLE;
               end
            end
            bctl_pkg::BCTL_ISSUE2: begin
               sfr.req <= 1'b1;
               sfr.we <= 1'b0;
               sfr.addr <= `BCTL_TUNING_ADDR;
               state <= bctl_pkg::BCTL_WAIT2;
            end
            default: begin
               if (sfr.ack) begin
                  state <= bctl_pkg::BCTL_IDLE;
               end
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Answers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         last_rdata <= 8'h00;
         hi_field <= 7'h00;
         lo_field <= 4'h0;
         ovf <= 1'b0;
         shadow_ptr <= 5'h1f;
      end else if (sfr.ack) begin
         last_rdata <= sfr.rdata;
         if (state == bctl_pkg::BCTL_WAIT2) begin
            lo_field <= sfr.rdata[7:4];
         end else if (seq) begin
            hi_field <= sfr.rdata[6:0];
            ovf <= sfr.rdata[`BCTL_OVF_BIT];
         end else if (!sfr.we && (sfr.addr == `BCTL_LOCK_ADDR)) begin
            shadow_ptr <= sfr.rdata[4:0];
         end
      end
   end

   // Refusal is sticky; an accepted order clears it.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         refused <= 1'b0;
      end else if (cmd_wr) begin
         refused <= busy || bad;
      end
   end

endmodule // bctl_host

/* verif/bctl_monitor.sv */
/*
 Concurrent checks on the register path and the cache write port.
 Assumes one clock and the interface signals handed in by name.
*/
`timescale 1ns/1ps

module bctl_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Register path
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata,
   // Fetch path and cache port
   input wire logic stall_i,
   input wire logic fill_i,
   input wire logic fill_table_read_i,
   input wire logic cache_wr_o,
   input wire logic [4:0] cache_wr_slot_o
);
   // ----------------------------------------------------------
   // Shadow state and checks
   // ----------------------------------------------------------
   logic [3:0] tun_m, lat_m;
   logic [4:0] ptr_m;
   logic [11:0] acc_m;
   logic [2:0] run_m;
   logic push_m, ovf_m;
   wire rd_t = req && !we && addr == 8'hc9;
   wire rd_l = req && !we && addr == 8'hd2;
   wire rd_a = req && !we && addr == 8'hd3;
   wire wr_l = req && we && addr == 8'hd2;
   wire wr_a = req && we && addr == 8'hd3;
   wire tr_push = fill_i && fill_table_read_i && push_m;
   wire [7:0] acc_hi = {ovf_m, acc_m[11:5]};
   wire [2:0] thr = {1'b0, tun_m[1:0]};

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tun_m <= 4'h4;
         lat_m <= 4'h0;
         push_m <= 1'b0;
         ptr_m <= 5'h1f;
      end else begin
         if (req && we && addr == 8'hc9) tun_m <= wdata[3:0];
         if (rd_a) lat_m <= acc_m[4:1];
         if (wr_l) push_m <= wdata[7];
         ptr_m <= ptr_m + {4'h0, wr_l && wdata[6]} - {4'h0, tr_push};
      end
   end

   // A write beats a stall increment, but an overflow in that cycle still sets the flag.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc_m <= 12'h000;
         ovf_m <= 1'b0;
         run_m <= 3'h0;
      end else begin
         if (wr_a) acc_m <= {wdata[6:0], 5'h00};
         else if (stall_i) acc_m <= acc_m + 12'h001;
         if (stall_i && acc_m == 12'hfff) ovf_m <= 1'b1;
         else if (wr_a) ovf_m <= 1'b0;
         if (fill_i) run_m <= 3'h0;
         else if (stall_i && run_m != 3'h7) run_m <= run_m + 3'h1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   AST_ACK_AFTER_REQ: assert property (req |=> ack)
      else $error("register request not answered next cycle");
   AST_ACK_HAS_REQ: assert property (ack |-> $past(req))
      else $error("answer without request");
   AST_WR_HAS_FILL: assert property (cache_wr_o |-> $past(fill_i))
      else $error("cache write without fill");
   AST_ABOVE_THR: assert property (fill_i && run_m > thr |=> cache_wr_o)
      else $error("cache write missing after long stall");
   AST_BELOW_THR: assert property (fill_i && !tr_push && run_m <= thr |=> !cache_wr_o)
      else $error("cache write after short stall");
   AST_THR_ZERO: assert property (fill_i && thr == 3'h0 && run_m != 3'h0 |=> cache_wr_o)
      else $error("stalling miss not cached at zero threshold");
   AST_FIX_SLOT: assert property (fill_i && fill_table_read_i && tun_m[2] && !push_m && run_m > thr
      |=> cache_wr_slot_o == 5'h00) else $error("table read fill not in slot 0");
   AST_PUSH_SLOT: assert property (tr_push |=> cache_wr_o && cache_wr_slot_o == $past(ptr_m))
      else $error("push fill not at pointer");
   AST_LOCK_READ: assert property (ack && $past(rd_l) |-> rdata == {$past(push_m), 2'b00, $past(ptr_m)})
      else $error("lock register read wrong");
   AST_TUN_READ: assert property (ack && $past(rd_t) |-> rdata == {$past(lat_m), $past(tun_m)})
      else $error("tuning register read wrong");
   AST_ACC_READ: assert property (ack && $past(rd_a) |-> rdata == $past(acc_hi))
      else $error("accumulator register read wrong");
   AST_SLOT_FREE: assert property (cache_wr_o && !$past(tr_push) && $past(ptr_m) != 5'h00
      |-> cache_wr_slot_o <= $past(ptr_m)) else $error("fill replaced a locked slot");

   cover property (tr_push);
   cover property (ack && $past(rd_a) && rdata[7]);
   cover property (fill_i && fill_table_read_i && tun_m[2]);
endmodule // bctl_monitor

/* verif/branch_cache_tuning_lock_bench.sv */
/*
 Self-checking bench: APB master, fetch path driver and result checker.
 Assumes both design ends share one clock and one interface.
*/
`timescale 1ns/1ps

module branch_cache_tuning_lock_bench;
   // ----------------------------------------------------------
   // Stimulus, checking and verdict
   // ----------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0, fill = 1'b0, ftr = 1'b0;
   logic [7:0] paddr = 8'h00, seen;
   logic [31:0] pwdata = 32'h0, prdata, st;
   logic pready, pslverr, cwr, up;
   logic [4:0] cslot;
   logic [7:0] exp_q[$];
   logic [4:0] slot_q[$];
   event got_ev;
   int failures = 0, cmp_count = 0, sum, n, bnc;

   always #12.5 clk_i = ~clk_i;

   bctl_if bus_if();
   bctl_device u_bctl_device (.clk_i(clk_i), .rst_b_i(rst_b_i), .sfr(bus_if), .stall_i(stall), .fill_i(fill),
      .fill_table_read_i(ftr), .cache_wr_o(cwr), .cache_wr_slot_o(cslot));
   bctl_host u_bctl_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .sfr(bus_if));
   bctl_monitor u_bctl_monitor (.clk_i(clk_i), .rst_b_i(rst_b_i), .req(bus_if.req), .we(bus_if.we),
      .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack), .rdata(bus_if.rdata), .stall_i(stall),
      .fill_i(fill), .fill_table_read_i(ftr), .cache_wr_o(cwr), .cache_wr_slot_o(cslot));

   task automatic stop_test();
      $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp_reg(input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch register byte expected %h seen %h", e, g);
      end
   endtask

   task automatic cmp_slot(input logic [4:0] e, input logic [4:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch cache_wr_slot expected %h seen %h", e, g);
      end
   endtask

   // Results are compared away from the driving process, oldest note first.
   always @(got_ev) cmp_reg(exp_q.pop_front(), seen);

   always @(negedge clk_i) begin
      if (cwr === 1'b1) begin
         if (slot_q.size() == 0) begin
            failures++;
            $display("mismatch cache_wr_o expected 0 seen 1");
         end else
            cmp_slot(slot_q.pop_front(), cslot);
      end
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready !== 1'b1 && k < 40);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 40) begin
         failures++;
         stop_test();
      end
   endtask

   // Each order is followed by polling busy, since the host refuses orders while busy.
   task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s = 1'b0);
      int k;
      k = 0;
      apb(1'b1, 8'h00, {14'h0, s, w, d, a}, st);
      do begin
         apb(1'b0, 8'h04, 32'h0, st);
         k++;
      end while (st[8] !== 1'b0 && k < 20);
      if (k >= 20) begin
         failures++;
         stop_test();
      end
   endtask

   task automatic note(input logic [7:0] e, input logic [7:0] s);
      exp_q.push_back(e);
      seen = s;
      -> got_ev;
   endtask

   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      dev(1'b0, a, 8'h00);
      note(e, st[7:0]);
   endtask

   task automatic miss(input int ns, input logic tr, input int sl);
      if (sl >= 0) slot_q.push_back(sl[4:0]);
      repeat (ns) begin
         stall <= 1'b1;
         @(posedge clk_i);
      end
      stall <= 1'b0;
      fill <= 1'b1;
      ftr <= tr;
      @(posedge clk_i);
      fill <= 1'b0;
      ftr <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   initial begin
      void'($urandom(47));
      repeat (16) @(posedge clk_i);
      rst_b_i <= 1'b1;
      chk(8'hc9, 8'h04);
      chk(8'hd2, 8'h1f);
      chk(8'hd3, 8'h00);
      chk(8'h55, 8'h00);
      apb(1'b0, 8'h08, 32'h0, st);
      note(8'h01, {7'h0, pslverr});
      $display("test reset values done");
      bnc = 0;
      up = 1'b1;
      for (int t = 0; t < 4; t++) begin
         dev(1'b1, 8'hc9, t[7:0]);
         miss(t, 1'b0, -1);
         miss(t + 1, 1'b0, bnc);
         bnc++;
      end
      dev(1'b1, 8'hc9, 8'h0c);
      miss(1, 1'b1, 0);
      dev(1'b1, 8'hc9, 8'h04);
      miss(2, 1'b1, 0);
      for (int i = 0; i < 31; i++) begin
         miss(1, 1'b0, bnc);
         if (bnc == 31) up = 1'b0;
         bnc = up ? bnc + 1 : bnc - 1;
      end
      $display("test threshold and replacement done");
      dev(1'b1, 8'hd2, 8'h80);
      miss(0, 1'b1, 31);
      miss(3, 1'b1, 30);
      chk(8'hd2, 8'h9d);
      dev(1'b1, 8'hd2, 8'h65);
      chk(8'hd2, 8'h1e);
      dev(1'b1, 8'hd2, 8'h60);
      note(8'h01, {7'h0, st[9]});
      chk(8'hd2, 8'h1e);
      $display("test lock stack done");
      dev(1'b1, 8'hc9, 8'hf3);
      dev(1'b1, 8'hd3, 8'h00);
      sum = 0;
      repeat (12) begin
         n = $urandom_range(3, 1);
         sum += n;
         miss(n, 1'b0, -1);
      end
      chk(8'hd3, {1'b0, sum[11:5]});
      chk(8'hc9, {sum[4:1], 4'h3});
      dev(1'b0, 8'h00, 8'h00, 1'b1);
      note({sum[7:1], 1'b0}, st[19:12]);
      $display("test accumulator done");
      dev(1'b1, 8'hd3, 8'h7f);
      miss(33, 1'b0, bnc);
      chk(8'hd3, 8'h80);
      chk(8'hc9, 8'h03);
      dev(1'b0, 8'h00, 8'h00, 1'b1);
      note(8'h01, {7'h0, st[24]});
      dev(1'b1, 8'hd3, 8'h01);
      chk(8'hd3, 8'h01);
      chk(8'hc9, 8'h03);
      $display("test overflow done");
      // The last note is compared only once this process yields.
      @(posedge clk_i);
      if (exp_q.size() != 0 || slot_q.size() != 0) begin
         failures++;
         $display("mismatch queues expected 0 seen %0d", exp_q.size() + slot_q.size());
      end
      stop_test();
   end
endmodule // branch_cache_tuning_lock_bench
